// File: pkg/aux_monitor_pkg.sv
// constants shared by the auxiliary measurement block
package aux_monitor_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] ADC_CONTROL_ADDR         = 7'h0f;
   localparam logic [6:0] BRIDGE_OFFSET_ADDR       = 7'h10;
   localparam logic [6:0] CONVERSION_RESULT_ADDR   = 7'h11;
   localparam logic [6:0] TEMP_SENSOR_CONTROL_ADDR = 7'h12;
   localparam logic [6:0] TEMP_VALUE_OFFSET_ADDR   = 7'h13;
   localparam logic [6:0] BATTERY_THRESHOLD_ADDR   = 7'h1a;
   localparam logic [6:0] BATTERY_LEVEL_ADDR       = 7'h1b;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADC_CONTROL_RESET         = 8'h00;
   localparam logic [7:0] BRIDGE_OFFSET_RESET       = 8'h00;
   localparam logic [7:0] TEMP_SENSOR_CONTROL_RESET = 8'h20;
   localparam logic [7:0] TEMP_VALUE_OFFSET_RESET   = 8'h00;
   localparam logic [7:0] BATTERY_THRESHOLD_RESET   = 8'h14;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int START_BIT       = 7;
   localparam int INPUT_SEL_LSB   = 4;
   localparam int REF_SEL_LSB     = 2;
   localparam int GAIN_SEL_LSB    = 0;
   localparam int SOFFS_LSB       = 0;
   localparam int RANGE_LSB       = 6;
   localparam int DIG_OFFS_EN_BIT = 5;
   localparam int TRIM_EN_BIT     = 4;
   localparam int TRIM_LSB        = 2;
   localparam int BG_TRIM_LSB     = 0;
   localparam int THRESHOLD_LSB   = 0;

   localparam logic [2:0] INPUT_TEMP_SENSOR = 3'h0;
   localparam logic [1:0] REF_BANDGAP       = 2'h0;
   localparam logic [2:0] BELOW_COUNT_NEED  = 3'h4;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int CONV_TIME_US    = 350;
   localparam int BATT_PERIOD_S   = 1;
   localparam int BATT_WINDOW_US  = 250;
   localparam int CONV_CYCLES     =
      (CONV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BATT_PERIOD_CYCLES =
      (BATT_PERIOD_S * 1000000000) / CLK_PERIOD_NS;
   localparam int BATT_WINDOW_CYCLES =
      (BATT_WINDOW_US * 1000) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // battery detector sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      batt_idle,
      batt_wait,
      batt_measure
   } batt_state_t;

endpackage

// File: hdl/cycle_timer.sv
// free counter that pulses once every COUNT enabled cycles
`timescale 1ns/1ps
module cycle_timer
   import aux_monitor_pkg::*;
#(
   parameter int COUNT = 16
) (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic clear_i,
   input  wire logic run_i,
   output logic      done_o
);
   localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;
   localparam logic [W-1:0] LAST = W'(COUNT - 1);

   initial begin
      if (COUNT < 2) begin
         $error("cycle_timer: COUNT must be at least 2");
      end
   end

   logic [W-1:0] count;

   always_ff @(posedge clk_i) begin
      if (srst_i || clear_i) begin
         count <= '0;
      end else if (run_i) begin
         count <= (count == LAST) ? '0 : count + 1'b1;
      end
   end

   assign done_o = run_i && !clear_i && (count == LAST);
endmodule

// File: hdl/spi_register_port.sv
// serial register port: r/w bit, 7-bit address, 8 data bits, msb first
`timescale 1ns/1ps
module spi_register_port
   import aux_monitor_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       sclk_i,
   input  wire logic       select_n_i,
   input  wire logic       sdi_i,
   output logic            sdo_o,
   output logic            sdo_oe_o,
   output logic [6:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   logic        sclk_q;
   logic [4:0]  bit_count;
   logic [14:0] shift_in;
   logic [7:0]  shift_out;
   logic        is_write;
   logic        load_pending;
   logic        rise;
   logic        fall;

   assign rise = sclk_i && !sclk_q && !select_n_i;
   assign fall = !sclk_i && sclk_q && !select_n_i;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk_i;
      end
   end

   // ----------------------------------------------------------------
   // receive side
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bit_count <= '0;
         shift_in  <= '0;
         is_write  <= 1'b0;
         addr_o    <= '0;
         wdata_o   <= '0;
         wr_o      <= 1'b0;
         rd_o      <= 1'b0;
      end else begin
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         if (select_n_i) begin
            bit_count <= '0;
         end else if (rise && bit_count < 5'd16) begin
            shift_in  <= {shift_in[13:0], sdi_i};
            bit_count <= bit_count + 5'd1;
            if (bit_count == 5'd7) begin
               addr_o   <= {shift_in[5:0], sdi_i};
               is_write <= shift_in[6];
               rd_o     <= !shift_in[6];
            end
            if (bit_count == 5'd15) begin
               wdata_o <= {shift_in[6:0], sdi_i};
               wr_o    <= is_write;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // transmit side, loaded two cycles after the address, then shifts on falling clock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         shift_out    <= '0;
         load_pending <= 1'b0;
      end else begin
         load_pending <= rd_o;
         if (load_pending) begin
            shift_out <= rdata_i;
         end else if (fall && bit_count > 5'd8) begin
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end

   assign sdo_o    = shift_out[7];
   assign sdo_oe_o = !select_n_i;
endmodule

// File: hdl/aux_monitor.sv
// auxiliary converter, temperature sensor and battery detector control
//
// Function
// - writing start bit begins conversion; device clears it when done, busy flag
// - conversion lasts 350 us; result valid after that or busy clear
// - input-select and reference-select fields steer converter; zero selects sensor, bandgap
// - bandgap span 0..1.02 V at 4 mV; other references rescale step
// - gain-select field for bridge amplifier; reference may be supply/2 or supply/3
// - 4-bit bridge offset field sets supply-dependent offset voltage
// - temperature sensor powered when selected or routed to analog test bus
// - range field picks temperature scale and step per code
// - digital offset enable adds temperature offset value to result
// - analog trim enable applies trim field to sensor circuit
// - detector enabled digitizes supply in 5 bits; level upper bits read zero
// - level below threshold with interrupt enabled drives active-low interrupt
// - four consecutive below-threshold readings needed before interrupt
// - detector powered once every second for about 250 us per reading
// - detector enabled in sleep starts the RC oscillator
// - battery code steps 50 mV from 1.7 V, 31 above 3.2 V
`timescale 1ns/1ps
module aux_monitor
   import aux_monitor_pkg::*;
#(
   parameter int CONV_COUNT         = CONV_CYCLES,
   parameter int BATT_PERIOD_COUNT  = BATT_PERIOD_CYCLES,
   parameter int BATT_WINDOW_COUNT  = BATT_WINDOW_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // serial register port
   input  wire logic       sclk_i,
   input  wire logic       select_n_i,
   input  wire logic       sdi_i,
   output logic            sdo_o,
   output logic            sdo_oe_o,
   // loose control from the rest of the chip
   input  wire logic       detector_enable_i,
   input  wire logic       battery_irq_enable_i,
   input  wire logic       status_read_i,
   input  wire logic       sleep_i,
   input  wire logic       test_bus_temp_i,
   // analog front end
   input  wire logic [7:0] converter_code_i,
   input  wire logic [4:0] battery_code_i,
   output logic            converter_power_o,
   output logic [2:0]      input_select_o,
   output logic [1:0]      reference_select_o,
   output logic [1:0]      gain_select_o,
   output logic [3:0]      bridge_offset_o,
   output logic            temp_sensor_on_o,
   output logic [1:0]      temp_range_o,
   output logic [1:0]      analog_trim_o,
   output logic [1:0]      bandgap_trim_o,
   output logic            battery_detector_power_o,
   output logic            rc_osc_enable_o,
   output logic            low_battery_flag_o,
   output logic            interrupt_out_n_o
);
   initial begin
      if (CONV_COUNT < 2 || BATT_WINDOW_COUNT < 2 ||
          BATT_PERIOD_COUNT <= BATT_WINDOW_COUNT) begin
         $error("aux_monitor: timing counts out of range");
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic [7:0] reg_rdata;

   spi_register_port u_port (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .sclk_i     (sclk_i),
      .select_n_i (select_n_i),
      .sdi_i      (sdi_i),
      .sdo_o      (sdo_o),
      .sdo_oe_o   (sdo_oe_o),
      .addr_o     (reg_addr),
      .wdata_o    (reg_wdata),
      .wr_o       (reg_wr),
      .rd_o       (),
      .rdata_i    (reg_rdata)
   );

   logic [6:0] adc_control;
   logic [3:0] bridge_offset;
   logic [7:0] conversion_result;
   logic [7:0] temp_sensor_control;
   logic [7:0] temp_value_offset;
   logic [4:0] battery_threshold;
   logic [4:0] battery_level;
   logic       busy;
   logic       conv_done;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         adc_control         <= ADC_CONTROL_RESET[6:0];
         bridge_offset       <= BRIDGE_OFFSET_RESET[3:0];
         temp_sensor_control <= TEMP_SENSOR_CONTROL_RESET;
         temp_value_offset   <= TEMP_VALUE_OFFSET_RESET;
         battery_threshold   <= BATTERY_THRESHOLD_RESET[4:0];
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADC_CONTROL_ADDR:         adc_control <= reg_wdata[6:0];
            BRIDGE_OFFSET_ADDR:       bridge_offset <= reg_wdata[3:0];
            TEMP_SENSOR_CONTROL_ADDR: temp_sensor_control <= reg_wdata;
            TEMP_VALUE_OFFSET_ADDR:   temp_value_offset <= reg_wdata;
            BATTERY_THRESHOLD_ADDR:   battery_threshold <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      reg_rdata = 8'h00;
      unique case (reg_addr)
         ADC_CONTROL_ADDR:         reg_rdata = {busy, adc_control};
         BRIDGE_OFFSET_ADDR:       reg_rdata = {4'h0, bridge_offset};
         CONVERSION_RESULT_ADDR:   reg_rdata = conversion_result;
         TEMP_SENSOR_CONTROL_ADDR: reg_rdata = temp_sensor_control;
         TEMP_VALUE_OFFSET_ADDR:   reg_rdata = temp_value_offset;
         BATTERY_THRESHOLD_ADDR:   reg_rdata = {3'h0, battery_threshold};
         BATTERY_LEVEL_ADDR:       reg_rdata = {3'h0, battery_level};
         default:                  reg_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // analog steering
   // ----------------------------------------------------------------
   assign input_select_o     = adc_control[INPUT_SEL_LSB +: 3];
   assign reference_select_o = adc_control[REF_SEL_LSB +: 2];
   assign gain_select_o      = adc_control[GAIN_SEL_LSB +: 2];
   assign bridge_offset_o    = bridge_offset[SOFFS_LSB +: 4];
   assign temp_range_o       = temp_sensor_control[RANGE_LSB +: 2];
   assign bandgap_trim_o     = temp_sensor_control[BG_TRIM_LSB +: 2];
   assign analog_trim_o      = temp_sensor_control[TRIM_EN_BIT] ?
                               temp_sensor_control[TRIM_LSB +: 2] :
                               2'h0;
   assign temp_sensor_on_o   = (input_select_o == INPUT_TEMP_SENSOR) ||
                               test_bus_temp_i;

   // ----------------------------------------------------------------
   // eight bit converter sequencing
   // ----------------------------------------------------------------
   logic start_req;

   assign start_req = reg_wr && (reg_addr == ADC_CONTROL_ADDR) &&
                      reg_wdata[START_BIT];

   cycle_timer #(
      .COUNT (CONV_COUNT)
   ) u_conv_timer (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .clear_i (!busy),
      .run_i   (busy),
      .done_o  (conv_done)
   );

   // a start written while busy is ignored, it does not restart
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy <= 1'b0;
      end else if (!busy && start_req) begin
         busy <= 1'b1;
      end else if (conv_done) begin
         busy <= 1'b0;
      end
   end

   assign converter_power_o = busy;

   // digital offset, saturating at full scale
   logic [8:0] offset_sum;

   assign offset_sum = {1'b0, converter_code_i} +
                       {1'b0, temp_value_offset};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         conversion_result <= 8'h00;
      end else if (conv_done) begin
         if (temp_sensor_control[DIG_OFFS_EN_BIT]) begin
            conversion_result <= offset_sum[8] ? 8'hff :
                                 offset_sum[7:0];
         end else begin
            conversion_result <= converter_code_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // battery detector
   // ----------------------------------------------------------------
   batt_state_t batt_state;
   logic        period_tick;
   logic        window_done;
   logic [2:0]  below_count;
   logic        below;
   logic        take_reading;

   cycle_timer #(
      .COUNT (BATT_PERIOD_COUNT)
   ) u_period_timer (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .clear_i (batt_state == batt_idle),
      .run_i   (batt_state != batt_idle),
      .done_o  (period_tick)
   );

   cycle_timer #(
      .COUNT (BATT_WINDOW_COUNT)
   ) u_window_timer (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .clear_i (batt_state != batt_measure),
      .run_i   (batt_state == batt_measure),
      .done_o  (window_done)
   );

   always_ff @(posedge clk_i) begin
      if (srst_i || !detector_enable_i) begin
         batt_state <= batt_idle;
      end else begin
         unique case (batt_state)
            batt_idle:    batt_state <= batt_measure;
            batt_wait:    if (period_tick) batt_state <= batt_measure;
            batt_measure: if (window_done) batt_state <= batt_wait;
            default:      batt_state <= batt_idle;
         endcase
      end
   end

   assign battery_detector_power_o = (batt_state == batt_measure);
   assign rc_osc_enable_o          = detector_enable_i && sleep_i;
   assign take_reading             = (batt_state == batt_measure) &&
                                     window_done;
   assign below = battery_code_i < battery_threshold;

   // level code passes straight from the 5-bit converter
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         battery_level <= 5'h00;
      end else if (take_reading) begin
         battery_level <= battery_code_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || !detector_enable_i) begin
         below_count <= 3'h0;
      end else if (take_reading) begin
         if (!below) begin
            below_count <= 3'h0;
         end else if (below_count < BELOW_COUNT_NEED) begin
            below_count <= below_count + 3'h1;
         end
      end
   end

   // set wins over the host's status read clear
   logic flag_set;

   assign flag_set = take_reading && below &&
                     (below_count >= BELOW_COUNT_NEED - 3'h1);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         low_battery_flag_o <= 1'b0;
      end else if (flag_set) begin
         low_battery_flag_o <= 1'b1;
      end else if (status_read_i) begin
         low_battery_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         interrupt_out_n_o <= 1'b1;
      end else begin
         interrupt_out_n_o <= !(low_battery_flag_o &&
                                battery_irq_enable_i);
      end
   end
endmodule

// File: verification/aux_monitor_properties.sv
// port assertions for the auxiliary monitor
`timescale 1ns/1ps
module aux_monitor_checker
   import aux_monitor_pkg::*;
#(
   parameter int CONV_COUNT        = 20,
   parameter int BATT_PERIOD_COUNT = 200,
   parameter int BATT_WINDOW_COUNT = 10
) (
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       select_n_i,
   input wire logic       detector_enable_i,
   input wire logic       battery_irq_enable_i,
   input wire logic       status_read_i,
   input wire logic       sleep_i,
   input wire logic       test_bus_temp_i,
   input wire logic       converter_power_o,
   input wire logic [2:0] input_select_o,
   input wire logic       temp_sensor_on_o,
   input wire logic       battery_detector_power_o,
   input wire logic       rc_osc_enable_o,
   input wire logic       low_battery_flag_o,
   input wire logic       interrupt_out_n_o
);
   logic [31:0] busy_cnt;
   logic [31:0] win_cnt;
   logic [31:0] gap;
   logic [2:0]  ends;
   logic        pw_q;
   logic        rst_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   always_ff @(posedge clk_i) begin
      rst_q <= srst_i;
      pw_q  <= battery_detector_power_o & ~srst_i;
   end
   // busy and window lengths
   always_ff @(posedge clk_i) begin
      busy_cnt <= (srst_i | ~converter_power_o) ? 32'h0 : busy_cnt + 32'h1;
      win_cnt  <= (srst_i | ~battery_detector_power_o) ? 32'h0 :
                  win_cnt + 32'h1;
   end
   // window spacing, readings since enable
   always_ff @(posedge clk_i) begin
      if (srst_i || !detector_enable_i) begin
         gap  <= 32'h0;
         ends <= 3'h0;
      end else begin
         if (battery_detector_power_o && !pw_q)
            gap <= 32'h1;
         else if (gap != 32'h0)
            gap <= gap + 32'h1;
         if (pw_q && !battery_detector_power_o && ends != 3'h7)
            ends <= ends + 3'h1;
      end
   end
   sequence fourth_reading;
      $fell(battery_detector_power_o) ##0 (ends >= 3'h3);
   endsequence
   a_busy_length: assert property (
      !rst_q && $fell(converter_power_o) |-> busy_cnt == CONV_COUNT)
      else $error("conversion busy time wrong");
   a_busy_start: assert property (
      $rose(converter_power_o) |-> !select_n_i)
      else $error("conversion began outside a write");
   a_sensor_power: assert property (
      temp_sensor_on_o ==
      (input_select_o == INPUT_TEMP_SENSOR || test_bus_temp_i))
      else $error("sensor power wrong");
   a_rc_osc_wake: assert property (
      rc_osc_enable_o == (detector_enable_i && sleep_i))
      else $error("rc oscillator enable wrong");
   a_irq_follow: assert property (
      !rst_q |-> interrupt_out_n_o ==
      !($past(low_battery_flag_o) && $past(battery_irq_enable_i)))
      else $error("interrupt line wrong");
   a_window_length: assert property (
      !rst_q && $past(detector_enable_i) && $fell(battery_detector_power_o)
      |-> win_cnt == BATT_WINDOW_COUNT)
      else $error("measure window length wrong");
   a_window_period: assert property (
      battery_detector_power_o && !pw_q && gap != 32'h0
      |-> gap == BATT_PERIOD_COUNT)
      else $error("measure period wrong");
   a_flag_four: assert property (
      $rose(low_battery_flag_o) |-> fourth_reading)
      else $error("flag set before four readings");
   a_flag_sticky: assert property (
      !rst_q && $fell(low_battery_flag_o) |-> $past(status_read_i))
      else $error("flag cleared without status read");
endmodule
bind aux_monitor aux_monitor_checker #(
   .CONV_COUNT(CONV_COUNT),
   .BATT_PERIOD_COUNT(BATT_PERIOD_COUNT),
   .BATT_WINDOW_COUNT(BATT_WINDOW_COUNT)
) i_aux_monitor_checker (
   .clk_i, .srst_i, .select_n_i, .detector_enable_i, .battery_irq_enable_i,
   .status_read_i, .sleep_i, .test_bus_temp_i, .converter_power_o,
   .input_select_o, .temp_sensor_on_o, .battery_detector_power_o,
   .rc_osc_enable_o, .low_battery_flag_o, .interrupt_out_n_o
);

// File: verification/host_mcu_model.sv
// host microcontroller model: serial register master and status reader
`timescale 1ns/1ps
module host_mcu_model (
   input  wire logic clk_i,
   input  wire logic sdo_i,
   output logic      sclk_o,
   output logic      select_n_o,
   output logic      sdi_o,
   output logic      status_read_o
);
   initial begin
      sclk_o        = 1'b0;
      select_n_o    = 1'b1;
      sdi_o         = 1'b0;
      status_read_o = 1'b0;
   end
   // one frame, msb first, clock idles low
   task automatic xfer(input logic w, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] word;
      word = {w, a, d};
      q    = 8'h00;
      @(posedge clk_i);
      select_n_o <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk_i);
         sdi_o <= word[i];
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         if (i < 8) q[i] = sdo_i;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      select_n_o <= 1'b1;
      sdi_o      <= ~sdi_o;
      repeat (4) @(posedge clk_i);
   endtask
   // interrupt status read
   task automatic ack_status();
      @(posedge clk_i);
      status_read_o <= 1'b1;
      @(posedge clk_i);
      status_read_o <= 1'b0;
   endtask
endmodule

// File: verification/aux_monitor_bench.sv
// self-checking bench for the auxiliary monitor block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) begin \
         err_count++; \
         $display("BAD %s exp %h got %h", nm, e, g); \
      end \
   end
module aux_monitor_bench
   import aux_monitor_pkg::*;
();
   int         err_count = 0;
   int         total_checks = 0;
   logic       clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       sclk_i, select_n_i, sdi_i, sdo_o, status_read_i;
   logic       detector_enable_i = 1'b0;
   logic       battery_irq_enable_i = 1'b0;
   logic       sleep_i = 1'b0;
   logic       test_bus_temp_i = 1'b0;
   logic [7:0] converter_code_i = 8'h00;
   logic [4:0] battery_code_i = 5'h00;
   logic [7:0] last = 8'h00;
   logic [2:0] s;
   logic       converter_power_o, temp_sensor_on_o, battery_detector_power_o;
   logic       rc_osc_enable_o, low_battery_flag_o, interrupt_out_n_o;
   logic [2:0] input_select_o;
   logic [1:0] reference_select_o, gain_select_o, temp_range_o;
   logic [1:0] analog_trim_o, bandgap_trim_o;
   logic [3:0] bridge_offset_o;
   always #4 clk_i = ~clk_i;
   aux_monitor #(.CONV_COUNT(400), .BATT_PERIOD_COUNT(200),
      .BATT_WINDOW_COUNT(10)) i_aux_monitor (
      .clk_i, .srst_i, .sclk_i, .select_n_i, .sdi_i, .sdo_o, .sdo_oe_o(),
      .detector_enable_i, .battery_irq_enable_i, .status_read_i, .sleep_i,
      .test_bus_temp_i, .converter_code_i, .battery_code_i,
      .converter_power_o, .input_select_o, .reference_select_o,
      .gain_select_o, .bridge_offset_o, .temp_sensor_on_o, .temp_range_o,
      .analog_trim_o, .bandgap_trim_o, .battery_detector_power_o,
      .rc_osc_enable_o, .low_battery_flag_o, .interrupt_out_n_o);
   host_mcu_model i_host_mcu_model (.clk_i(clk_i), .sdo_i(sdo_o),
      .sclk_o(sclk_i), .select_n_o(select_n_i), .sdi_o(sdi_i),
      .status_read_o(status_read_i));
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_host_mcu_model.xfer(1'b1, a, d, q);
   endtask
   task automatic check_reg(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      i_host_mcu_model.xfer(1'b0, a, 8'h00, q);
      `CHK("register", e, q)
   endtask
   task automatic convert(input logic [7:0] code, input logic [7:0] e);
      logic [7:0] q;
      int         n;
      n = 0;
      q = 8'h80;
      @(posedge clk_i);
      converter_code_i <= code;
      reg_write(ADC_CONTROL_ADDR, 8'h80);
      check_reg(ADC_CONTROL_ADDR, 8'h80);
      check_reg(CONVERSION_RESULT_ADDR, last);
      while (q[START_BIT] !== 1'b0 && n < 10) begin
         i_host_mcu_model.xfer(1'b0, ADC_CONTROL_ADDR, 8'h00, q);
         n++;
      end
      check_reg(CONVERSION_RESULT_ADDR, e);
      last = e;
   endtask
   task automatic wait_end();
      int n;
      n = 0;
      while (battery_detector_power_o !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      while (battery_detector_power_o !== 1'b0 && n < 800) begin
         @(negedge clk_i);
         n++;
      end
      `CHK("window", 1'b1, n < 800)
   endtask
   task give_verdict();
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      check_reg(ADC_CONTROL_ADDR, ADC_CONTROL_RESET);
      check_reg(BRIDGE_OFFSET_ADDR, BRIDGE_OFFSET_RESET);
      check_reg(TEMP_SENSOR_CONTROL_ADDR, TEMP_SENSOR_CONTROL_RESET);
      check_reg(TEMP_VALUE_OFFSET_ADDR, TEMP_VALUE_OFFSET_RESET);
      check_reg(BATTERY_THRESHOLD_ADDR, BATTERY_THRESHOLD_RESET);
      check_reg(BATTERY_LEVEL_ADDR, 8'h00);
      check_reg(7'h20, 8'h00);
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         reg_write(ADC_CONTROL_ADDR, {1'b0, s, s[1:0], ~s[1:0]});
         `CHK("input_select", s, input_select_o)
         `CHK("reference", s[1:0], reference_select_o)
         `CHK("gain", ~s[1:0], gain_select_o)
         `CHK("sensor_on", s == 3'h0, temp_sensor_on_o)
      end
      test_bus_temp_i <= 1'b1;
      @(negedge clk_i);
      `CHK("test_bus_on", 1'b1, temp_sensor_on_o)
      reg_write(BRIDGE_OFFSET_ADDR, 8'h09);
      `CHK("bridge_offset", 4'h9, bridge_offset_o)
      for (int i = 0; i < 4; i++) begin
         reg_write(TEMP_SENSOR_CONTROL_ADDR, {i[1:0], 6'h16});
         `CHK("range", i[1:0], temp_range_o)
         `CHK("trim", 2'h1, analog_trim_o)
         `CHK("bg_trim", 2'h2, bandgap_trim_o)
      end
      reg_write(TEMP_SENSOR_CONTROL_ADDR, 8'h0c);
      `CHK("trim_off", 2'h0, analog_trim_o)
      reg_write(ADC_CONTROL_ADDR, 8'h00);
      reg_write(TEMP_SENSOR_CONTROL_ADDR, 8'h60);
      reg_write(TEMP_VALUE_OFFSET_ADDR, 8'h10);
      convert(8'h30, 8'h40);
      convert(8'hf8, 8'hff);
      reg_write(TEMP_SENSOR_CONTROL_ADDR, 8'h40);
      convert(8'h37, 8'h37);
      reg_write(BATTERY_THRESHOLD_ADDR, 8'h10);
      battery_code_i       <= 5'h0f;
      battery_irq_enable_i <= 1'b1;
      detector_enable_i    <= 1'b1;
      sleep_i              <= 1'b1;
      @(negedge clk_i);
      `CHK("rc_osc", 1'b1, rc_osc_enable_o)
      repeat (2) wait_end();
      @(posedge clk_i);
      battery_code_i <= 5'h10;
      wait_end();
      @(posedge clk_i);
      battery_code_i <= 5'h0f;
      repeat (3) wait_end();
      `CHK("flag_early", 1'b0, low_battery_flag_o)
      wait_end();
      `CHK("flag", 1'b1, low_battery_flag_o)
      @(negedge clk_i);
      `CHK("irq_low", 1'b0, interrupt_out_n_o)
      check_reg(BATTERY_LEVEL_ADDR, 8'h0f);
      @(posedge clk_i);
      battery_code_i       <= 5'h1f;
      battery_irq_enable_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK("irq_masked", 1'b1, interrupt_out_n_o)
      battery_irq_enable_i <= 1'b1;
      wait_end();
      i_host_mcu_model.ack_status();
      repeat (2) @(negedge clk_i);
      `CHK("flag_clear", 1'b0, low_battery_flag_o)
      `CHK("irq_high", 1'b1, interrupt_out_n_o)
      detector_enable_i <= 1'b0;
      @(negedge clk_i);
      `CHK("rc_off", 1'b0, rc_osc_enable_o)
      give_verdict();
   end
endmodule
